/* File: pkg/cabinet_defs.vh */
`ifndef CABINET_DEFS_VH
`define CABINET_DEFS_VH
// Register byte offsets on the APB.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MODFLT 12'h008
`define REG_CHAN 12'h00C
`define REG_PORTA 12'h010
`define REG_PORTB 12'h014
`define REG_DEVADDR 12'h018
// Control register fields.
`define CTRL_RESET_BIT 0
`define CTRL_OFF_BIT 1
`define CTRL_SLAVE_RST_BIT 2
`define CTRL_RESET_VAL 32'h00000000
// Timing: clock period in ns and one-shot widths.
`define CLK_PERIOD_NS 100
`define SUPPLY_PULSE_MS 500
`define SUPPLY_PULSE_CYC ((`SUPPLY_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define RESTART_PULSE_CYC 16
`define SUPPLY_SETTLE_MS 800
`define SUPPLY_SETTLE_CYC ((`SUPPLY_SETTLE_MS * 1000000) / `CLK_PERIOD_NS)
// Analog channel codes.
`define CHAN_LAST_RF 8'h05
`define CHAN_S1_VOLT 8'h07
`define CHAN_S1_CURR 8'h17
`define CHAN_S2_VOLT 8'h27
`define CHAN_S2_CURR 8'h37
`define NUM_MODULES 16
`endif

/* File: rtl/pin_sync.v */
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree.
module pin_sync
#(
  parameter W = 1
)
(
  input wire clk, // Clock.
  input wire rst, // Asynchronous reset, active high.
  input wire [W-1:0] din, // Asynchronous level.
  output reg [W-1:0] dout // Filtered synchronous level.
);
  reg [W-1:0] s1_q; // First stage, read only by the second.
  reg [W-1:0] s2_q; // Second stage.
  reg [W-1:0] s3_q; // Third stage.
  integer i;

  // Shift and accept a bit only once two later stages agree.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* File: rtl/cabinet_slave_control.v */
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cabinet_defs.vh"
// Overview of operation
// - Reset, door or off command blocks on.
// - Held local off overrides remote on.
// - On-command pulse restarts only faulted modules.
// - Supplies need latch on, air, door shut.
// - Failed supply control pulses high 500 ms.
// - Four faults sum into red indicator.
// - When off, report only door fault.
// - Turn-on sets drive state to one.
// - Supply good clears supply faults.
// - Drive state one forces enables off.
// - No fault: gate one, enable low.
// - Fault: gate zero, enable high.
// - Enable line is inverted gate output.
// - Latch channel address, select channel.
// - Codes 00-05 select RF detectors.
// - Codes 07, 17, 27 and 37 select supply readings.
// - Read select freezes and drives status.
// - Changeover faults hold until slave reset.
// - Second port passes live levels.
// - Monitor address latched, compared on strobe.
module cabinet_slave_control
#(
  parameter SUPPLY_PULSE_CYC = `SUPPLY_PULSE_CYC, // Supply restart width.
  parameter SUPPLY_SETTLE_CYC = `SUPPLY_SETTLE_CYC, // Supply good timeout.
  parameter RESTART_PULSE_CYC = `RESTART_PULSE_CYC, // Module restart width.
  parameter SLAVE_ADDR = 8'h01 // Unused; the slave address resets to 00 and is set over the APB.
)
(
  input wire CLK, // System clock, 10 MHz.
  input wire RST, // Asynchronous reset, active high.
  input wire PSEL, // APB select.
  input wire PENABLE, // APB enable.
  input wire PWRITE, // APB direction.
  input wire [11:0] PADDR, // APB byte address.
  input wire [31:0] PWDATA, // APB write data.
  output reg [31:0] PRDATA, // APB read data.
  output reg PREADY, // APB ready.
  output reg PSLVERR, // APB error on unmapped address.
  input wire CABINET_ON_COMMAND, // Remote on line, high means on.
  input wire CABINET_OFF_COMMAND, // Remote off line, high means off.
  input wire LOCAL_OFF_BUTTON, // Local off pushbutton, high while held.
  input wire DOOR_OPEN, // Door interlock, high when open.
  input wire AIR_CLOSED, // Air switch closed, blower running.
  input wire SUPPLY_ONE_GOOD, // Supply one good.
  input wire SUPPLY_TWO_GOOD, // Supply two good.
  input wire [15:0] MODULE_FAULT_FLAG, // Per-module fault flags.
  input wire AURAL_CHANGEOVER_FAULT, // Aural fault from changeover logic.
  input wire VISUAL_CHANGEOVER_FAULT, // Visual fault from changeover logic.
  input wire [7:0] SPARE_STATUS, // Live inputs of the second port.
  input wire [7:0] BUS_AD, // Monitor bus address lines.
  input wire COMMAND_DATA_SELECT, // High at command level.
  input wire WRITE_STROBE_N, // Write strobe, active low.
  input wire READ_SELECT_N, // Status read select, active low.
  output reg CABINET_ON, // Contactor drive, latch on.
  output reg SUPPLY_ENABLE, // Both supplies enabled.
  output reg SUPPLY_ONE_CONTROL, // Supply one control line.
  output reg SUPPLY_TWO_CONTROL, // Supply two control line.
  output reg FAULT_LED, // Red summary fault indicator.
  output reg [15:0] MODULE_ENABLE, // Module enable lines, low enables.
  output reg [3:0] ANALOG_SELECT, // Analog mux select, 15 is none.
  output reg [7:0] STATUS_DATA, // Data toward monitor bus drivers.
  output reg STATUS_DATA_OE_N, // Low while driving the data lines.
  output reg SELECT_LED // Slave selected by the monitor.
);
  // Synchronised pin inputs.
  wire [31:0] raw_pins;
  wire [31:0] sync_pins;
  wire [15:0] mod_flt;
  wire [7:0] spare_s;
  wire on_cmd, off_cmd, loc_off, door, air, s1_good, s2_good;
  wire aur_co, vis_co, cds, wr_n, rd_n;
  wire [7:0] ad_s;
  wire [7:0] ad_pins;
  wire wr_act, rd_act; // Strobes, synchronised active high.

  assign raw_pins = {MODULE_FAULT_FLAG, SPARE_STATUS, CABINET_ON_COMMAND,
    CABINET_OFF_COMMAND, LOCAL_OFF_BUTTON, DOOR_OPEN, AIR_CLOSED,
    SUPPLY_ONE_GOOD, SUPPLY_TWO_GOOD, AURAL_CHANGEOVER_FAULT};

  // All pins cross from outside the clock domain through three stages.
  pin_sync #(.W(32)) u_sync_a
  (
    .clk(CLK),
    .rst(RST),
    .din(raw_pins),
    .dout(sync_pins)
  );

  // The strobes pass inverted, so the stages reset to their idle level;
  // otherwise a false strobe edge would follow every reset.
  pin_sync #(.W(12)) u_sync_b
  (
    .clk(CLK),
    .rst(RST),
    .din({VISUAL_CHANGEOVER_FAULT, COMMAND_DATA_SELECT, ~WRITE_STROBE_N,
      ~READ_SELECT_N, BUS_AD}),
    .dout({vis_co, cds, wr_act, rd_act, ad_pins})
  );

  assign mod_flt = sync_pins[31:16];
  assign spare_s = sync_pins[15:8];
  assign on_cmd = sync_pins[7];
  assign off_cmd = sync_pins[6];
  assign loc_off = sync_pins[5];
  assign door = sync_pins[4];
  assign air = sync_pins[3];
  assign s1_good = sync_pins[2];
  assign s2_good = sync_pins[1];
  assign aur_co = sync_pins[0];
  assign ad_s = ad_pins;
  assign wr_n = ~wr_act;
  assign rd_n = ~rd_act;

  // Software control bits and state.
  reg [2:0] ctrl_q; // Soft reset, soft off, slave reset.
  reg [7:0] dev_addr_q; // Slave address, set over the APB.
  reg on_q; // Cabinet on/off latch.
  reg on_cmd_q; // Previous on command, for edge detect.
  reg drive_q; // Transmit drive state.
  reg [23:0] restart_cnt_q; // Module restart one-shot counter.
  reg [23:0] s1_cnt_q; // Supply one pulse counter.
  reg [23:0] s2_cnt_q; // Supply two pulse counter.
  reg [23:0] settle_cnt_q; // Time since air established.
  reg s1_flt_q; // Supply one fault.
  reg s2_flt_q; // Supply two fault.
  reg wr_n_q; // Previous write strobe.
  reg [7:0] cmd_addr_q; // Latched command address.
  reg [7:0] chan_q; // Latched analog channel code.
  reg aur_hold_q, vis_hold_q; // Held changeover faults.
  reg aur_prev_q, vis_prev_q; // Previous changeover levels.
  reg rd_n_q; // Previous read select.
  reg [7:0] frozen_q; // Frozen status byte.

  wire restart_act;
  wire blocked;
  wire summary;
  wire [7:0] report;
  wire hit;

  // The latch reset input: any of these prevents the on state.
  assign blocked = ctrl_q[`CTRL_RESET_BIT] | door | off_cmd | loc_off |
    ctrl_q[`CTRL_OFF_BIT];
  assign restart_act = (restart_cnt_q != 24'h000000);
  // Air loss counts while the cabinet runs or is turning on.
  assign summary = ((drive_q | on_q) & ~air) | door | s1_flt_q |
    s2_flt_q;
  // Off state masks all but the door fault.
  assign report = on_q ? {4'h0, s2_flt_q, s1_flt_q, door, ~air} :
    {5'h00, 1'b0, door, 1'b0};
  assign hit = (cmd_addr_q == dev_addr_q);

  // Cabinet latch, drive state and restart one-shots.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      on_q <= 1'b0;
      on_cmd_q <= 1'b0;
      drive_q <= 1'b0;
      restart_cnt_q <= 24'h000000;
      s1_cnt_q <= 24'h000000;
      s2_cnt_q <= 24'h000000;
    end
    else
    begin
      on_cmd_q <= on_cmd;
      // Blocked wins; on returns when the override is released while the on command is high.
      if (blocked)
      begin
        on_q <= 1'b0;
      end
      else if (on_cmd)
      begin
        on_q <= 1'b1;
      end
      // Drive state rises with the latch itself, not with every on
      // pulse, so a restart pulse leaves healthy modules on the air.
      if (!on_q)
      begin
        drive_q <= ~blocked & on_cmd;
      end
      else if (air)
      begin
        drive_q <= 1'b0;
      end
      // A rising on command fires the restart one-shot and the one-shot of each faulted supply.
      if (on_cmd && !on_cmd_q)
      begin
        restart_cnt_q <= RESTART_PULSE_CYC[23:0];
        if (s1_flt_q)
        begin
          s1_cnt_q <= SUPPLY_PULSE_CYC[23:0];
        end
        if (s2_flt_q)
        begin
          s2_cnt_q <= SUPPLY_PULSE_CYC[23:0];
        end
      end
      else
      begin
        if (restart_act)
        begin
          restart_cnt_q <= restart_cnt_q - 24'h000001;
        end
        if (s1_cnt_q != 24'h000000)
        begin
          s1_cnt_q <= s1_cnt_q - 24'h000001;
        end
        if (s2_cnt_q != 24'h000000)
        begin
          s2_cnt_q <= s2_cnt_q - 24'h000001;
        end
      end
    end
  end

  // Supply faults: raised when supply good fails to arrive in time.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      settle_cnt_q <= 24'h000000;
      s1_flt_q <= 1'b0;
      s2_flt_q <= 1'b0;
    end
    else
    begin
      if (!on_q || !air)
      begin
        settle_cnt_q <= 24'h000000;
      end
      else if (settle_cnt_q != SUPPLY_SETTLE_CYC[23:0])
      begin
        settle_cnt_q <= settle_cnt_q + 24'h000001;
      end
      // Supply good clears the fault at once.
      if (s1_good)
      begin
        s1_flt_q <= 1'b0;
      end
      else if (on_q && (!air || settle_cnt_q == SUPPLY_SETTLE_CYC[23:0]))
      begin
        s1_flt_q <= 1'b1;
      end
      if (s2_good)
      begin
        s2_flt_q <= 1'b0;
      end
      else if (on_q && (!air || settle_cnt_q == SUPPLY_SETTLE_CYC[23:0]))
      begin
        s2_flt_q <= 1'b1;
      end
    end
  end

  // Outputs to the cabinet hardware.
  integer m;
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CABINET_ON <= 1'b0;
      SUPPLY_ENABLE <= 1'b0;
      SUPPLY_ONE_CONTROL <= 1'b0;
      SUPPLY_TWO_CONTROL <= 1'b0;
      FAULT_LED <= 1'b0;
      MODULE_ENABLE <= 16'hFFFF;
    end
    else
    begin
      CABINET_ON <= on_q;
      SUPPLY_ENABLE <= on_q & air & ~door;
      SUPPLY_ONE_CONTROL <= (s1_cnt_q != 24'h000000);
      SUPPLY_TWO_CONTROL <= (s2_cnt_q != 24'h000000);
      FAULT_LED <= summary;
      for (m = 0; m < `NUM_MODULES; m = m + 1)
      begin
        // Gate is one for a healthy module with drive state low;
        // the enable line is its inverse. A faulted module also sees
        // the restart pulse, which drives it low to reset it.
        if (drive_q)
        begin
          MODULE_ENABLE[m] <= 1'b1;
        end
        else if (!mod_flt[m])
        begin
          MODULE_ENABLE[m] <= 1'b0;
        end
        else
        begin
          MODULE_ENABLE[m] <= ~restart_act;
        end
      end
    end
  end

  // Monitor bus: address strobe, channel latch and status ports.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      cmd_addr_q <= 8'hFF;
      chan_q <= 8'h06;
      frozen_q <= 8'h00;
      aur_hold_q <= 1'b0;
      vis_hold_q <= 1'b0;
      aur_prev_q <= 1'b0;
      vis_prev_q <= 1'b0;
      SELECT_LED <= 1'b0;
      ANALOG_SELECT <= 4'hF;
      STATUS_DATA <= 8'h00;
      STATUS_DATA_OE_N <= 1'b1;
    end
    else
    begin
      wr_n_q <= wr_n;
      rd_n_q <= rd_n;
      aur_prev_q <= aur_co;
      vis_prev_q <= vis_co;
      // Rising strobe latches command address or channel code.
      if (wr_n && !wr_n_q)
      begin
        if (cds)
        begin
          cmd_addr_q <= ad_s;
        end
        else if (hit)
        begin
          chan_q <= ad_s;
        end
      end
      SELECT_LED <= hit;
      // Channel decode; unused codes leave the mux deselected.
      if (chan_q <= `CHAN_LAST_RF)
      begin
        ANALOG_SELECT <= chan_q[3:0];
      end
      else if (chan_q == `CHAN_S1_VOLT)
      begin
        ANALOG_SELECT <= 4'h6;
      end
      else if (chan_q == `CHAN_S1_CURR)
      begin
        ANALOG_SELECT <= 4'h7;
      end
      else if (chan_q == `CHAN_S2_VOLT)
      begin
        ANALOG_SELECT <= 4'h8;
      end
      else if (chan_q == `CHAN_S2_CURR)
      begin
        ANALOG_SELECT <= 4'h9;
      end
      else
      begin
        ANALOG_SELECT <= 4'hF;
      end
      // Changeover faults latch on their rising edge, held to reset.
      if (ctrl_q[`CTRL_SLAVE_RST_BIT])
      begin
        aur_hold_q <= aur_co & ~aur_prev_q;
        vis_hold_q <= vis_co & ~vis_prev_q;
      end
      else
      begin
        aur_hold_q <= aur_hold_q | (aur_co & ~aur_prev_q);
        vis_hold_q <= vis_hold_q | (vis_co & ~vis_prev_q);
      end
      // Falling read select freezes the byte for the whole read.
      if (!rd_n && rd_n_q)
      begin
        frozen_q <= {aur_hold_q, vis_hold_q, 1'b0, 1'b0, report[3:0]};
      end
      // Port one when address bit 0 low, live port two when high.
      STATUS_DATA_OE_N <= ~(~rd_n & hit & ~rd_n_q);
      STATUS_DATA <= cmd_addr_q[0] ? spare_s : frozen_q;
    end
  end

  // APB slave, zero wait states.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q <= 3'h0;
      dev_addr_q <= 8'h00;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      // Slave reset is a self-clearing pulse.
      ctrl_q[`CTRL_SLAVE_RST_BIT] <= 1'b0;
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE)
      begin
        PRDATA <= 32'h00000000;
        case (PADDR)
          `REG_CTRL:
            PRDATA <= {29'h00000000, ctrl_q};
          `REG_STATUS:
            PRDATA <= {22'h000000, aur_hold_q, vis_hold_q, drive_q, on_q,
              SUPPLY_ENABLE, FAULT_LED, report[3:0]};
          `REG_MODFLT:
            PRDATA <= {16'h0000, mod_flt};
          `REG_CHAN:
            PRDATA <= {24'h000000, chan_q};
          `REG_PORTA:
            PRDATA <= {24'h000000, frozen_q};
          `REG_PORTB:
            PRDATA <= {24'h000000, spare_s};
          `REG_DEVADDR:
            PRDATA <= {24'h000000, dev_addr_q};
          default:
            PSLVERR <= 1'b1;
        endcase
      end
      // Writes land only at the edge that completes the access phase.
      if (PSEL && PENABLE && PREADY && PWRITE)
      begin
        if (PADDR == `REG_CTRL)
        begin
          ctrl_q <= PWDATA[2:0];
        end
        if (PADDR == `REG_DEVADDR)
        begin
          dev_addr_q <= PWDATA[7:0];
        end
      end
    end
  end
endmodule

/* File: dv/cabinet_checker.sv */
`timescale 1ns/1ps
// Watches the cabinet control block from its pins alone.
module cabinet_checker
#(
  parameter int SUPPLY_PULSE_CYC = 20 // Supply restart width in cycles.
)
(
  input logic CLK, // Clock.
  input logic RST, // Asynchronous reset, active high.
  input logic PSEL, // APB select.
  input logic PENABLE, // APB enable.
  input logic PREADY, // APB ready.
  input logic PSLVERR, // APB error.
  input logic DOOR_OPEN, // Door interlock.
  input logic LOCAL_OFF_BUTTON, // Local off button.
  input logic READ_SELECT_N, // Status read select.
  input logic CABINET_ON, // Latch state.
  input logic SUPPLY_ENABLE, // Supply enable.
  input logic SUPPLY_ONE_CONTROL, // Supply one control.
  input logic FAULT_LED, // Red lamp.
  input logic STATUS_DATA_OE_N // Status drive enable.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  int hi_q; // Cycles the supply one line has stood high.
  // Counts the high run, so a line stuck high overruns the limit.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      hi_q <= 0;
    end
    else
    begin
      hi_q <= SUPPLY_ONE_CONTROL ? hi_q + 1 : 0;
    end
  end
  // Eight samples cover the three-flop synchroniser and output register.
  a_door_blocks_on: assert property (DOOR_OPEN[*8] |-> !CABINET_ON)
    else $error("cabinet on with door open");
  a_local_off_wins: assert property (
    LOCAL_OFF_BUTTON[*8] |-> !CABINET_ON)
    else $error("cabinet on while local off held");
  a_supply_needs_on: assert property (
    $fell(CABINET_ON) |-> ##[0:2] !SUPPLY_ENABLE)
    else $error("supplies left on after cabinet off");
  a_supply_door_shut: assert property (
    DOOR_OPEN[*8] |-> !SUPPLY_ENABLE)
    else $error("supplies on with door open");
  a_door_lights_lamp: assert property (DOOR_OPEN[*8] |-> FAULT_LED)
    else $error("door fault missing from lamp");
  a_pulse_max_width: assert property (hi_q <= SUPPLY_PULSE_CYC)
    else $error("supply one control too long");
  a_pulse_min_width: assert property (
    $rose(SUPPLY_ONE_CONTROL) |-> SUPPLY_ONE_CONTROL[*8])
    else $error("supply one control too short");
  // The drive follows a read select seen six samples back, which covers
  // the synchroniser, the edge register and the output register.
  a_drive_in_read: assert property (
    !STATUS_DATA_OE_N |-> !$past(READ_SELECT_N, 6))
    else $error("status driven outside a read");
  a_drive_needs_read: assert property (
    READ_SELECT_N[*6] |-> STATUS_DATA_OE_N)
    else $error("status driven without read select");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  a_error_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  c_restart: cover property ($rose(SUPPLY_ONE_CONTROL));
  c_read: cover property ($fell(STATUS_DATA_OE_N));
  c_refused: cover property (PSLVERR);
endmodule
bind cabinet_slave_control cabinet_checker
  #(.SUPPLY_PULSE_CYC(SUPPLY_PULSE_CYC)) chk (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DOOR_OPEN(DOOR_OPEN), .LOCAL_OFF_BUTTON(LOCAL_OFF_BUTTON),
  .READ_SELECT_N(READ_SELECT_N), .CABINET_ON(CABINET_ON),
  .SUPPLY_ENABLE(SUPPLY_ENABLE), .SUPPLY_ONE_CONTROL(SUPPLY_ONE_CONTROL),
  .FAULT_LED(FAULT_LED), .STATUS_DATA_OE_N(STATUS_DATA_OE_N));

/* File: dv/monitor_model.sv */
`timescale 1ns/1ps
// Monitor at the far end of the monitor bus.
module monitor_model
(
  input logic clk, // Bench clock.
  input logic [7:0] status_data, // Byte from the slave.
  input logic status_data_oe_n, // Low while the slave drives.
  output logic [7:0] bus_ad, // Address and data lines.
  output logic cds, // High at command level.
  output logic write_strobe_n, // Write strobe, active low.
  output logic read_select_n // Read select, active low.
);
  localparam int HOLD = 6; // Levels outlast the slave's synchroniser.
  // Bus starts idle with strobes high.
  initial
  begin
    bus_ad = 8'hFF;
    cds = 1'b0;
    write_strobe_n = 1'b1;
    read_select_n = 1'b1;
  end
  // Places a byte, strobes it, then lets the lines wander off it.
  task automatic put(input logic cmd, input logic [7:0] v);
  begin
    @(posedge clk);
    bus_ad <= v;
    cds <= cmd;
    repeat (HOLD) @(posedge clk);
    write_strobe_n <= 1'b0;
    repeat (HOLD) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (HOLD) @(posedge clk);
    bus_ad <= ~v;
  end
  endtask
  // Read cycle after an address; the drive stands while read select is held low.
  task automatic get(output logic [7:0] d, output logic seen);
  begin
    seen = 1'b0;
    d = 8'h00;
    @(posedge clk);
    read_select_n <= 1'b0;
    repeat (HOLD * 2)
    begin
      @(posedge clk);
      if (status_data_oe_n === 1'b0)
      begin
        d = status_data;
        seen = 1'b1;
      end
    end
    read_select_n <= 1'b1;
    repeat (HOLD) @(posedge clk);
  end
  endtask
endmodule

/* File: dv/tb_cabinet_slave_control.sv */
`timescale 1ns/1ps
`include "cabinet_defs.vh"
// Self-checking bench for the cabinet control block.
module tb_cabinet_slave_control;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e, s, low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic on_cmd, off_cmd, loff, door, air, s1g, s2g, aural, visual;
  logic [15:0] mff, men, mask;
  logic [7:0] spare, ad, d;
  logic cds, wsn, rsn, cabinet_on_command, sup_en, s1c, s2c, led, soe_n, sel_led;
  logic [3:0] asel;
  logic [14:0] h;
  int err_total, checks_done, cnt, bad;
  // Rows: {on, off, local off, door, air}, then {on, supplies, lamp}.
  logic [7:0] rows [8] = '{8'h8E, 8'h99, 8'h8E, 8'hA8, 8'h8E, 8'hC8,
    8'h8E, 8'h85};
  // Channel code, then the select it should give.
  logic [11:0] chans [9] = '{12'h000, 12'h011, 12'h022, 12'h033,
    12'h044, 12'h055, 12'h06F, 12'h47F, 12'h77F};
  logic [7:0] sup_codes [4] = '{8'h07, 8'h17, 8'h27, 8'h37};
  // Short counts keep the run brief.
  cabinet_slave_control #(.SUPPLY_PULSE_CYC(20), .SUPPLY_SETTLE_CYC(30))
    DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CABINET_ON_COMMAND(on_cmd),
    .CABINET_OFF_COMMAND(off_cmd), .LOCAL_OFF_BUTTON(loff),
    .DOOR_OPEN(door), .AIR_CLOSED(air), .SUPPLY_ONE_GOOD(s1g),
    .SUPPLY_TWO_GOOD(s2g), .MODULE_FAULT_FLAG(mff),
    .AURAL_CHANGEOVER_FAULT(aural), .VISUAL_CHANGEOVER_FAULT(visual),
    .SPARE_STATUS(spare), .BUS_AD(ad), .COMMAND_DATA_SELECT(cds),
    .WRITE_STROBE_N(wsn), .READ_SELECT_N(rsn), .CABINET_ON(cabinet_on_command),
    .SUPPLY_ENABLE(sup_en), .SUPPLY_ONE_CONTROL(s1c),
    .SUPPLY_TWO_CONTROL(s2c), .FAULT_LED(led), .MODULE_ENABLE(men),
    .ANALOG_SELECT(asel), .STATUS_DATA(d), .STATUS_DATA_OE_N(soe_n),
    .SELECT_LED(sel_led));
  logic [7:0] got;
  monitor_model mon (.clk(clk), .status_data(d), .status_data_oe_n(soe_n),
    .bus_ad(ad), .cds(cds), .write_strobe_n(wsn), .read_select_n(rsn));
  // Ten megahertz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One APB transfer; holds everything until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd);
    int n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Waits as long as the slave needs; only the watchdog ends a hang.
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
  begin
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  end
  endtask
  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  end
  endtask
  // A hang ends the run through the same verdict.
  initial
  begin
    #4000000;
    err_total++;
    test_done;
  end
  // Main sequence: table first, then the awkward cases.
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    {on_cmd, off_cmd, loff, door, air, aural, visual} = '0;
    {s1g, s2g, mff, spare} = {2'h3, 16'h0000, 8'h00};
    tick(8);
    rst <= 1'b0;
    tick(2);
    apb(0, `REG_DEVADDR, 0);
    chk(r, 32'h00000000);
    foreach (rows[i])
    begin
      {on_cmd, off_cmd, loff, door, air} <= rows[i][7:3];
      tick(12);
      chk({cabinet_on_command, sup_en, led}, rows[i][2:0]);
    end
    air <= 1'b1;
    tick(40);
    apb(0, `REG_STATUS, 0);
    chk(r & 32'h0000037F, 32'h00000060);
    apb(0, 12'h0FC, 0);
    chk({e, r[30:0]}, 32'h80000000);
    apb(1, `REG_CTRL, 1);
    tick(8);
    chk(cabinet_on_command, 0);
    apb(1, `REG_CTRL, 0);
    tick(8);
    chk(cabinet_on_command, 1);
    // Failed supply one and one faulted module, then an on pulse.
    s1g <= 1'b0;
    mff <= 16'h0001;
    tick(40);
    {h, cnt, low, bad} = {men[15:1], 32'h0, 1'b0, 32'h0};
    on_cmd <= 1'b0;
    tick(6);
    on_cmd <= 1'b1;
    repeat (60)
    begin
      @(posedge clk);
      cnt += s1c;
      low |= !men[0];
      bad += (men[15:1] !== h);
    end
    chk(cnt, 20);
    chk(low, 1);
    chk(bad, 0);
    // Supply one still failed: fault reported and lamp lit, until good.
    apb(0, `REG_STATUS, 0);
    chk(r[4:0], 5'h14);
    s1g <= 1'b1;
    tick(8);
    apb(0, `REG_STATUS, 0);
    chk(r[4:0], 5'h00);
    {s1g, mff, door, air} <= {1'b1, 16'h0000, 2'b10};
    on_cmd <= 1'b0;
    tick(12);
    apb(0, `REG_STATUS, 0);
    chk(r[3:0], 4'h2);
    {door, air, on_cmd} <= 3'b011;
    // A changeover fault holds until the slave reset.
    aural <= 1'b1;
    tick(6);
    aural <= 1'b0;
    tick(8);
    apb(0, `REG_STATUS, 0);
    chk(r[9], 1);
    apb(1, `REG_CTRL, 4);
    tick(8);
    apb(0, `REG_STATUS, 0);
    chk(r[9], 0);
    mon.put(1, 8'h00);
    tick(2);
    chk(sel_led, 1);
    mon.get(got, s);
    chk({s, got}, 9'h100);
    foreach (chans[i])
    begin
      mon.put(0, chans[i][11:4]);
      tick(4);
      chk(asel, chans[i][3:0]);
    end
    mask = 16'h0000;
    foreach (sup_codes[i])
    begin
      mon.put(0, sup_codes[i]);
      tick(4);
      chk(asel > 5 && asel !== 4'hF, 1);
      mask |= 16'h0001 << asel;
    end
    chk($countones(mask), 4);
    apb(1, `REG_DEVADDR, 1);
    spare <= 8'hA5;
    mon.put(1, 8'h01);
    mon.get(got, s);
    chk({s, got}, 9'h1A5);
    mon.put(1, 8'h02);
    tick(2);
    chk(sel_led, 0);
    mon.get(got, s);
    chk(s, 0);
    // Mid-run reset, then release: the latch returns on the held command.
    rst <= 1'b1;
    tick(2);
    chk({men, asel, soe_n, cabinet_on_command}, {16'hFFFF, 4'hF, 2'h2});
    rst <= 1'b0;
    tick(12);
    chk(cabinet_on_command, 1);
    test_done;
  end
endmodule
